// ===== rtl/mspi_cfg.svh
// constants for the master serial engine
`ifndef MSPI_CFG_SVH
`define MSPI_CFG_SVH
`define MSPI_MODE_SEL_SPI 2'h3
`define MSPI_DIV_RESET 12'h000
`define MSPI_FRAME_BITS 4'h8
`define MSPI_CTRL_C_RESET 8'h06
`define MSPI_POS_MODE_HI 7
`define MSPI_POS_MODE_LO 6
`define MSPI_POS_ORDER 2
`define MSPI_POS_PHASE 1
`define MSPI_POS_POLARITY 0
`endif

// ===== rtl/mspi_pkg.sv
// types shared by the master serial engine
package mspi_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b10
  } xfer_state_e;
endpackage : mspi_pkg

// ===== rtl/baud_gen.sv
// baud tick generator: one tick per half bit period
`timescale 1ns/1ps
`include "mspi_cfg.svh"
module baud_gen #(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reload,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;

  // (R5) half period count
  // (R14) prescaler starts from the zero divisor
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= `MSPI_DIV_RESET;
    end else if (reload || cnt_q == '0) begin
      cnt_q <= divisor;
    end else begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign tick = (cnt_q == '0) && !reload;
endmodule : baud_gen

// ===== rtl/mspi_master.sv
// master-only serial peripheral engine built from the serial port resources
// ----------------------------------------------------------------
// How it works
// (R1) mode field 11 selects the common transfer control
// (R2) no parity, recovery or async control
// (R3) only internal clock, always master
// (R4) software sets clock pin as output
// (R5) bit rate is clk over 2(div+1)
// (R6) polarity and phase pick modes 0-3
// (R7) shift and sample on opposite edges
// (R8) software keeps mode bits still mid-transfer
// (R9) eight bits per frame, idle high after
// (R10) one bit order for both directions
// (R11) order bit one sends lsb first
// (R12) two writes give sixteen bits, one complete
// (R13) software enables transmitter with divisor zero
// (R14) divisor resets to zero
// (R15) low byte write reloads prescaler now
// (R16) runs only with transmitter enabled
// (R17) enables take over data pins
// (R18) data buffer write starts a transfer
// (R19) buffer moves to shifter when ready
// (R20) overflow drops newest byte
// (R21) receive holds two buffered plus shifter
// (R22) software reads once per byte sent
// (R23) empty and receive complete flags
// (R24) error flags always read zero
// (R25) software clears complete before each write
// (R26) transmit disable waits for empty
// (R27) receive disable flushes buffer
// (R28) clock idles at polarity level
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "mspi_cfg.svh"
module mspi_master
  import mspi_pkg::*;
#(
  parameter int DIV_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] mode_select_field,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic bit_order_bit,
  input wire logic transmit_enable_bit,
  input wire logic receive_enable_bit,
  input wire logic clock_pin_direction,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic baud_divisor_low_wr,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdata,
  input wire logic data_rd,
  input wire logic transmit_complete_clr,
  input wire logic serial_in_pin,
  output logic [DATA_W-1:0] data_rdata,
  output logic buffer_empty_flag,
  output logic receive_complete_flag,
  output logic transmit_complete_flag,
  output logic framing_error_flag,
  output logic overrun_flag,
  output logic parity_error_flag,
  output logic serial_clock_pin,
  output logic serial_clock_oe_b,
  output logic serial_out_pin,
  output logic serial_out_oe_b,
  output logic serial_in_owned
);
  // ----------------------------------------------------------------
  // mode and enables
  // ----------------------------------------------------------------
  xfer_state_e state_q;
  logic tx_on_q;
  logic tick;
  logic [DATA_W-1:0] tx_buf_q;
  logic tx_full_q;
  logic [DATA_W-1:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic rx_bit_q;
  logic sck_q;
  logic sdo_q;
  logic [DATA_W-1:0] rx_mem_q [2];
  logic [1:0] rx_cnt_q;
  logic rd_ptr_q;
  logic sel_spi;
  logic run;
  logic load;
  logic frame_done;
  logic push;
  logic pop;
  logic [DATA_W-1:0] rx_byte;
  logic sample_lead;

  // (R1) mode select gates the engine
  assign sel_spi = (mode_select_field == `MSPI_MODE_SEL_SPI);
  // (R16) engine needs the transmitter
  // (R3) clock made internally; a clock pin set as input keeps a new transfer from loading, a running frame still finishes
  assign run = sel_spi && tx_on_q && clock_pin_direction;

  // (R26) disable waits for shifter and buffer to drain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_on_q <= 1'b0;
    end else if (transmit_enable_bit) begin
      tx_on_q <= 1'b1;
    end else if (!tx_full_q && state_q == ST_IDLE) begin
      tx_on_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // (R15) low byte write reloads the prescaler
  baud_gen #(.DIV_W(DIV_W)) u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .reload(baud_divisor_low_wr),
    .divisor(baud_divisor),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  // (R19) buffered byte moves to the shifter as soon as it is free
  assign load = run && tx_full_q && state_q == ST_IDLE;

  // (R18) a data write queues a transfer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_full_q <= 1'b0;
      tx_buf_q <= '0;
    end else if (data_wr && sel_spi && (transmit_enable_bit || tx_on_q)) begin
      tx_full_q <= 1'b1;
      tx_buf_q <= data_wdata;
    end else if (load) begin
      tx_full_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  // leading edge samples when phase is zero (modes 0 and 2)
  assign sample_lead = !clock_phase_bit;
  // (R9) frame ends after eight trailing edges
  assign frame_done = tick && state_q == ST_TRAIL && bit_cnt_q == `MSPI_FRAME_BITS - 4'h1;

  // (R11) order bit picks the outgoing end of the shifter
  function automatic logic out_bit(input logic [DATA_W-1:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[DATA_W-1];
  endfunction : out_bit

  // (R10) one shifter serves both directions with one order
  function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] v,
                                                 input logic b, input logic lsb);
    shift_in = lsb ? {b, v[DATA_W-1:1]} : {v[DATA_W-2:0], b};
  endfunction : shift_in

  // (R7) setup on one edge, sample on the other
  // (R6) polarity and phase choose edge roles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      shift_q <= '0;
      bit_cnt_q <= '0;
      rx_bit_q <= 1'b0;
      sck_q <= 1'b0;
      sdo_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // (R28) clock rests at its polarity level
          sck_q <= clock_polarity_bit;
          if (load) begin
            shift_q <= tx_buf_q;
            bit_cnt_q <= '0;
            sdo_q <= out_bit(tx_buf_q, bit_order_bit);
            state_q <= ST_LEAD;
          end else begin
            // (R9) line idles high between frames
            sdo_q <= 1'b1;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            sck_q <= !clock_polarity_bit;
            if (sample_lead) begin
              rx_bit_q <= serial_in_pin;
            end else if (bit_cnt_q != '0) begin
              shift_q <= shift_in(shift_q, rx_bit_q, bit_order_bit);
              sdo_q <= out_bit(shift_in(shift_q, rx_bit_q, bit_order_bit), bit_order_bit);
            end
            state_q <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            sck_q <= clock_polarity_bit;
            if (sample_lead) begin
              shift_q <= shift_in(shift_q, rx_bit_q, bit_order_bit);
              sdo_q <= out_bit(shift_in(shift_q, rx_bit_q, bit_order_bit), bit_order_bit);
            end else begin
              rx_bit_q <= serial_in_pin;
              if (bit_cnt_q == `MSPI_FRAME_BITS - 4'h1) begin
                shift_q <= shift_in(shift_q, serial_in_pin, bit_order_bit);
              end
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
            state_q <= frame_done ? ST_IDLE : ST_LEAD;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit complete
  // ----------------------------------------------------------------
  // (R12) complete only when nothing more is queued; set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transmit_complete_flag <= 1'b0;
    end else if (frame_done && !tx_full_q) begin
      transmit_complete_flag <= 1'b1;
    end else if (transmit_complete_clr) begin
      transmit_complete_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  // mode 1 and 3 take the final bit straight from the pin
  assign rx_byte = sample_lead ? shift_in(shift_q, rx_bit_q, bit_order_bit)
                               : shift_in(shift_q, serial_in_pin, bit_order_bit);
  assign pop = data_rd && rx_cnt_q != 2'h0;
  // (R20) a full buffer drops the newest byte
  // (R21) two buffered entries; the shifter is the third
  assign push = frame_done && receive_enable_bit && (rx_cnt_q != 2'h2 || pop);

  // (R27) receive disable flushes the buffer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt_q <= 2'h0;
      rd_ptr_q <= 1'b0;
    end else if (!receive_enable_bit) begin
      rx_cnt_q <= 2'h0;
      rd_ptr_q <= 1'b0;
    end else begin
      rx_cnt_q <= rx_cnt_q + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_rx
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        rx_mem_q[i] <= '0;
      // slot follows the read pointer as it stands after this cycle's pop
      end else if (push && (rd_ptr_q ^ pop ^ (rx_cnt_q - {1'b0, pop} != 2'h0)) == 1'(i)) begin
        rx_mem_q[i] <= rx_byte;
      end
    end
  end

  // (R23) flags report buffer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_rdata <= '0;
      receive_complete_flag <= 1'b0;
      buffer_empty_flag <= 1'b1;
    end else begin
      data_rdata <= rx_mem_q[rd_ptr_q];
      receive_complete_flag <= receive_enable_bit && rx_cnt_q != 2'h0;
      buffer_empty_flag <= !tx_full_q;
    end
  end

  // ----------------------------------------------------------------
  // pins and error flags
  // ----------------------------------------------------------------
  // clock and data pins come straight from the engine flops so that the
  // input is sampled on the same cycle as the edge seen on the pin
  assign serial_clock_pin = sck_q;
  assign serial_out_pin = sdo_q;

  // (R17) enables take over the data pins
  // (R2) error flags stay clear with no parity or recovery
  // (R24) error flags tied low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_clock_oe_b <= 1'b1;
      serial_out_oe_b <= 1'b1;
      serial_in_owned <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end else begin
      serial_clock_oe_b <= !(sel_spi && clock_pin_direction);
      serial_out_oe_b <= !(sel_spi && tx_on_q);
      serial_in_owned <= sel_spi && receive_enable_bit;
      framing_error_flag <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_IDLE_CLOCK: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_IDLE |=> sck_q == $past(clock_polarity_bit)) // R28
    else $error("clock left idle level");
  AST_NO_RUN: assert property (@(posedge clk) disable iff (!rst_b)
    !sel_spi |-> state_q == ST_IDLE || $past(sel_spi)) // R1
    else $error("transfer started outside spi mode");
  AST_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    load |=> state_q == ST_LEAD && tx_full_q == $past(data_wr)) // R19
    else $error("buffer not moved to shifter");
  AST_ERR_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 !(framing_error_flag || overrun_flag || parity_error_flag)) // R24
    else $error("error flag set");
  AST_DROP: assert property (@(posedge clk) disable iff (!rst_b)
    frame_done && rx_cnt_q == 2'h2 && !pop && receive_enable_bit |=> rx_cnt_q == 2'h2) // R20
    else $error("overflow changed buffer count");
  AST_FLUSH: assert property (@(posedge clk) disable iff (!rst_b)
    !receive_enable_bit |=> rx_cnt_q == 2'h0) // R27
    else $error("receive buffer not flushed");
  AST_TX_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    tx_on_q && state_q != ST_IDLE |=> tx_on_q) // R26
    else $error("transmitter dropped mid frame");
  AST_TXC: assert property (@(posedge clk) disable iff (!rst_b)
    frame_done && !tx_full_q |=> transmit_complete_flag) // R12
    else $error("transmit complete missing");
  AST_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_LEAD && tick |=> sck_q != clock_polarity_bit) // R7
    else $error("leading edge missing");
endmodule : mspi_master

// ===== verification/spi_slave_model.sv
// behavioural serial slave that answers the master engine
`timescale 1ns/1ps
module spi_slave_model (
  input wire logic sck,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic mosi,
  input wire logic arm,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  // ------------------------------------------------------------
  // wire order, msb of each byte first on the line
  // ------------------------------------------------------------
  logic [7:0] rep;
  int n;
  wire logic s = sck ^ cpol ^ cpha;
  initial begin
    miso = 1'b1;
    got = 8'h00;
    rep = 8'h00;
    n = 0;
  end
  // first bit ready before the leading edge when phase is zero
  always @(posedge arm) begin
    rep = reply;
    got = 8'h00;
    n = cpha ? 0 : 1;
    miso = cpha ? ~miso : reply[7];
  end
  always @(posedge s) got = {got[6:0], mosi};
  // setup edge; each following frame answers with the next value
  always @(negedge s) begin
    if (n == 8) begin
      rep = rep + 8'h01;
      n = 0;
    end
    miso = rep[7 - n];
    n = n + 1;
  end
endmodule : spi_slave_model

// ===== verification/tb_mspi_master.sv
// self-checking bench for the master serial engine
`timescale 1ns/1ps
module tb_mspi_master;
  logic clk, rst_b, cpol, cpha, lsb, txen, rxen, dir, low_wr, wr_p, rd_p, clr, arm;
  logic [1:0] msel;
  logic [11:0] div;
  logic [7:0] wdata, rdata, reply, got, lf, b;
  logic be, rc, tc, fe, ov, pe, sck, sck_oe_b, sdo, sdo_oe_b, in_own, miso;
  int n_fail, total_checks, cyc, nedge, t1, hp;
  mspi_master i_mspi_master (.clk(clk), .rst_b(rst_b), .mode_select_field(msel),
    .clock_polarity_bit(cpol), .clock_phase_bit(cpha), .bit_order_bit(lsb),
    .transmit_enable_bit(txen), .receive_enable_bit(rxen), .clock_pin_direction(dir),
    .baud_divisor(div), .baud_divisor_low_wr(low_wr), .data_wr(wr_p), .data_wdata(wdata),
    .data_rd(rd_p), .transmit_complete_clr(clr), .serial_in_pin(miso), .data_rdata(rdata),
    .buffer_empty_flag(be), .receive_complete_flag(rc), .transmit_complete_flag(tc),
    .framing_error_flag(fe), .overrun_flag(ov), .parity_error_flag(pe),
    .serial_clock_pin(sck), .serial_clock_oe_b(sck_oe_b), .serial_out_pin(sdo),
    .serial_out_oe_b(sdo_oe_b), .serial_in_owned(in_own));
  spi_slave_model i_spi_slave_model (.sck(sck), .cpol(cpol), .cpha(cpha), .mosi(sdo),
    .arm(arm), .reply(reply), .miso(miso), .got(got));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nxt
  // wire carries msb first unless lsb order is chosen
  function automatic logic [7:0] ord(input logic [7:0] x, input logic l);
    logic [7:0] r;
    for (int k = 0; k < 8; k++) r[k] = l ? x[7 - k] : x[k];
    return r;
  endfunction : ord
  task automatic results;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask : chkb
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc_n
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc_n(1);
    s = 1'b0;
  endtask : pulse
  task automatic waitf(input int w);
    int k;
    for (k = 0; k < 3000; k++) begin
      if ((w == 0 && tc === 1'b1) || (w == 1 && be === 1'b1) || (w == 2 && rc === 1'b1)) break;
      cyc_n(1);
    end
    chkb(k < 3000, 1'b1);
  endtask : waitf
  task automatic wr(input logic [7:0] d);
    wdata = d;
    wr_p = 1'b1;
    cyc_n(1);
    wr_p = 1'b0;
    cyc_n(1);
  endtask : wr
  task automatic rd(input logic [7:0] e);
    waitf(2);
    cyc_n(1);
    chk(rdata, e);
    pulse(rd_p);
    cyc_n(1);
  endtask : rd
  task automatic start(input logic [7:0] r);
    reply = r;
    pulse(arm);
    // clear the complete flag before the writes that follow
    pulse(clr);
    nedge = 0;
  endtask : start
  // ------------------------------------------------------------
  // clock, edge timing and timeout
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 40000) begin
      n_fail++;
      results();
    end
  end
  always @(sck) begin
    nedge = nedge + 1;
    if (nedge == 1) t1 = cyc;
    if (nedge == 2) hp = cyc - t1;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {cpol, cpha, lsb, txen, rxen, dir, low_wr, wr_p, rd_p, clr, arm} = '0;
    {n_fail, total_checks, cyc, nedge, t1, hp} = '0;
    msel = 2'h0;
    div = 12'h000;
    wdata = 8'h00;
    reply = 8'h00;
    lf = 8'h10;
    rst_b = 1'b0;
    cyc_n(5);
    rst_b = 1'b1;
    msel = 2'h3;
    dir = 1'b1;
    // divisor still zero when the transmitter is enabled
    txen = 1'b1;
    rxen = 1'b1;
    cyc_n(3);
    chk({5'h00, sck_oe_b, sdo_oe_b, in_own}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      // mode bits change only while idle
      {lsb, cpha, cpol} = i[2:0];
      lf = nxt(lf);
      div = {10'h000, lf[1:0]};
      pulse(low_wr);
      cyc_n(10);
      chkb(sck, cpol);
      lf = nxt(lf);
      b = lf;
      lf = nxt(lf);
      start(lf);
      wr(b);
      waitf(0);
      chk(hp[7:0], {6'h00, div[1:0]} + 8'h01);
      chk(nedge[7:0], 8'h10);
      chk(got, ord(b, lsb));
      chkb(sck, cpol);
      rd(ord(reply, lsb));
      chk({5'h00, fe, ov, pe}, 8'h00);
    end
    // two writes back to back give one sixteen bit sequence
    start(8'hA5);
    wdata = 8'h3C;
    wr_p = 1'b1;
    cyc_n(1);
    wdata = 8'hC3;
    cyc_n(1);
    wr_p = 1'b0;
    cyc_n(1);
    chkb(be, 1'b0);
    waitf(0);
    chk(nedge[7:0], 8'h20);
    rd(ord(8'hA5, lsb));
    rd(ord(8'hA6, lsb));
    // four unread frames overflow the receive side
    start(8'h50);
    for (int k = 0; k < 4; k++) begin
      waitf(1);
      wr(8'h11 * k[7:0]);
    end
    waitf(0);
    rd(ord(8'h50, lsb));
    rd(ord(8'h51, lsb));
    chkb(ov, 1'b0);
    rxen = 1'b0;
    cyc_n(2);
    chkb(rc, 1'b0);
    results();
  end
endmodule : tb_mspi_master
